// ---- src/iod_decode_core.sv ----
// Purpose: decode and timing of sign extension, flag clear, compare, cmov
// Assumes: fetch strips displacement and index bytes; operands hit
// Notes:   all state is one struct, registered once per clock

`timescale 1ns/1ps

module iod_decode_core
    import iod_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // instruction byte stream
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteData,
    output logic             byteReady,
    // mode and operand values
    input  wire logic        protMode,
    input  wire logic        privOk,
    input  wire logic        taskSwitchSet,
    input  wire logic [31:0] accValue,
    input  wire logic [31:0] regValue,
    input  wire logic [31:0] rmValue,
    // decoded modrm fields
    output logic [1:0]       modrmMod,
    output logic [2:0]       modrmReg,
    output logic [2:0]       modrmRm,
    output logic             rmIsReg,
    // retirement and writeback
    output logic             instrDone,
    output logic             badOpcode,
    output logic             modeFault,
    output logic             wbValid,
    output logic [2:0]       wbReg,
    output logic [31:0]      wbData,
    // status flags
    output logic             carryFlag,
    output logic             directionFlag,
    output logic             intEnableFlag,
    output logic             overflowFlag,
    output logic             signFlag,
    output logic             zeroFlag,
    output logic             auxCarryFlag,
    output logic             parityFlag,
    output logic             taskSwitched
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        iod_state_t  state;
        iod_kind_t   kind;
        logic [3:0]  cnt;
        logic [7:0]  opc;
        logic [1:0]  immIdx;
        logic [1:0]  immLast;
        logic [31:0] imm;
        logic [1:0]  mod;
        logic [2:0]  reg3;
        logic [2:0]  rm;
        logic        rdy;
        logic        done;
        logic        bad;
        logic        fault;
        logic        wbV;
        logic [2:0]  wbR;
        logic [31:0] wbD;
        logic        cf;
        logic        df;
        logic        ief;
        logic        of;
        logic        sf;
        logic        zf;
        logic        af;
        logic        pf;
        logic        ts;
    } iod_core_t;

    iod_core_t s_r;
    iod_core_t s_nxt;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // returns {of, sf, zf, af, pf, cf} of a minus b
    function automatic logic [5:0] cmpFlags(input logic [31:0] a,
                                            input logic [31:0] b,
                                            input logic        isByte);
        logic [32:0] d;
        logic [8:0]  d8;
        logic [31:0] r;
        logic        o;
        logic        c;
        logic        sg;
        d  = {1'b0, a} - {1'b0, b};
        d8 = {1'b0, a[7:0]} - {1'b0, b[7:0]};
        if (isByte) begin
            r  = {24'h000000, d8[7:0]};
            c  = d8[8];
            sg = d8[7];
            o  = (a[7] ^ b[7]) & (a[7] ^ d8[7]);
        end else begin
            r  = d[31:0];
            c  = d[32];
            sg = d[31];
            o  = (a[31] ^ b[31]) & (a[31] ^ d[31]);
        end
        return {o, sg, (r == 32'h00000000), a[4] ^ b[4] ^ r[4], ~^r[7:0], c};
    endfunction

    function automatic logic condMet(input logic [3:0] cc,
                                     input logic       o,
                                     input logic       sg,
                                     input logic       z,
                                     input logic       p,
                                     input logic       c);
        logic t;
        case (cc[3:1])
            CC_OVF:      t = o;
            CC_CARRY:    t = c;
            CC_ZERO:     t = z;
            CC_BELOW_EQ: t = c | z;
            CC_SIGN:     t = sg;
            CC_PARITY:   t = p;
            CC_LESS:     t = sg ^ o;
            CC_LESS_EQ:  t = z | (sg ^ o);
            default:     t = 1'b0;
        endcase
        return t ^ cc[0];
    endfunction

    function automatic iod_core_t goExec(input iod_core_t x,
                                         input iod_kind_t k,
                                         input logic [3:0] c);
        iod_core_t y;
        y       = x;
        y.kind  = k;
        y.cnt   = c;
        y.state = ST_EXEC;
        return y;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic [31:0] opA;
    logic [31:0] opB;
    logic [5:0]  cmpRes;
    logic        isByteOp;
    logic        memOp;

    always_comb begin
        memOp    = (s_r.mod != MOD_REGISTER);
        isByteOp = ~s_r.opc[BIT_W];
        opA      = rmValue;
        opB      = regValue;
        // operand order per form; d bit picks reg minus r/m
        if (s_r.opc[7:1] == CMP_ACC_HI) begin
            opA = accValue;
            opB = s_r.imm;
        end else if (s_r.opc[7:2] == CMP_GRP_HI) begin
            opB = s_r.imm;
            if (s_r.opc[BIT_DS] && s_r.opc[BIT_W]) begin
                opB = {{24{s_r.imm[7]}}, s_r.imm[7:0]};
            end
        end else if (s_r.opc[BIT_DS]) begin
            opA = regValue;
            opB = rmValue;
        end
        cmpRes = cmpFlags(opA, opB, isByteOp);

        s_nxt       = s_r;
        s_nxt.done  = 1'b0;
        s_nxt.bad   = 1'b0;
        s_nxt.fault = 1'b0;
        s_nxt.wbV   = 1'b0;
        case (s_r.state)
            ST_IDLE: begin
                if (byteValid) begin
                    s_nxt.opc    = byteData;
                    s_nxt.imm    = 32'h00000000;
                    s_nxt.immIdx = 2'h0;
                    s_nxt.kind   = K_NONE;
                    if (byteData == OP_SEXT_BW) begin
                        s_nxt = goExec(s_nxt, K_SEXT_BW, CYC_SEXT_BW);
                    end else if (byteData == OP_SEXT_DQ) begin
                        s_nxt = goExec(s_nxt, K_SEXT_DQ, CYC_SEXT_DQ);
                    end else if (byteData == OP_CLR_CARRY) begin
                        s_nxt = goExec(s_nxt, K_CLR_CARRY, CYC_CLR_CY);
                    end else if (byteData == OP_CLR_DIR) begin
                        s_nxt = goExec(s_nxt, K_CLR_DIR, CYC_CLR_DIR);
                    end else if (byteData == OP_CLR_INTEN) begin
                        s_nxt = goExec(s_nxt, K_CLR_INTEN, CYC_CLR_IE);
                    end else if (byteData == OP_INV_CARRY) begin
                        s_nxt = goExec(s_nxt, K_INV_CARRY, CYC_INV_CY);
                    end else if (byteData == OP_ESCAPE) begin
                        s_nxt.state = ST_ESC;
                    end else if (byteData[7:2] == CMP_MODRM_HI ||
                                 byteData[7:2] == CMP_GRP_HI) begin
                        s_nxt.kind  = K_CMP;
                        s_nxt.state = ST_MODRM;
                    end else if (byteData[7:1] == CMP_ACC_HI) begin
                        s_nxt.kind    = K_CMP;
                        s_nxt.immLast = byteData[BIT_W] ? IMM_LAST_D
                                                        : IMM_LAST_B;
                        s_nxt.state   = ST_IMM;
                    end else begin
                        s_nxt.bad = 1'b1;
                    end
                end
            end
            ST_ESC: begin
                if (byteValid) begin
                    if (byteData == OP2_CLR_TS) begin
                        s_nxt = goExec(s_nxt, K_CLR_TS, CYC_CLR_TS);
                    end else if (byteData[7:4] == CMOV_HI) begin
                        s_nxt.opc   = byteData;
                        s_nxt.kind  = K_CMOV;
                        s_nxt.state = ST_MODRM;
                    end else begin
                        s_nxt.bad   = 1'b1;
                        s_nxt.state = ST_IDLE;
                    end
                end
            end
            ST_MODRM: begin
                if (byteValid) begin
                    s_nxt.mod  = byteData[7:6];
                    s_nxt.reg3 = byteData[5:3];
                    s_nxt.rm   = byteData[2:0];
                    if (s_r.kind == K_CMOV) begin
                        s_nxt = goExec(s_nxt, K_CMOV, CYC_CMOV);
                    end else if (s_r.opc[7:2] != CMP_GRP_HI) begin
                        s_nxt = goExec(s_nxt, K_CMP, CYC_CMP);
                    end else if (byteData[5:3] == GRP_REG_CMP) begin
                        // sign-extended and byte forms carry one byte
                        s_nxt.immLast = (s_r.opc[BIT_DS] | ~s_r.opc[BIT_W])
                                      ? IMM_LAST_B : IMM_LAST_D;
                        s_nxt.state   = ST_IMM;
                    end else begin
                        s_nxt.bad   = 1'b1;
                        s_nxt.state = ST_IDLE;
                    end
                end
            end
            ST_IMM: begin
                if (byteValid) begin
                    s_nxt.imm = s_r.imm
                              | (32'(byteData) << {s_r.immIdx, 3'b000});
                    if (s_r.immIdx == s_r.immLast) begin
                        s_nxt = goExec(s_nxt, K_CMP, CYC_CMP);
                    end else begin
                        s_nxt.immIdx = s_r.immIdx + 2'h1;
                    end
                end
            end
            ST_EXEC: begin
                if (s_r.cnt != CNT_LAST) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    s_nxt.state = ST_IDLE;
                    s_nxt.done  = 1'b1;
                    case (s_r.kind)
                        K_SEXT_BW: begin
                            s_nxt.wbV = 1'b1;
                            s_nxt.wbR = REG_ACC;
                            s_nxt.wbD = {accValue[31:16],
                                         {8{accValue[7]}}, accValue[7:0]};
                        end
                        K_SEXT_DQ: begin
                            s_nxt.wbV = 1'b1;
                            s_nxt.wbR = REG_DATA;
                            s_nxt.wbD = {32{accValue[31]}};
                        end
                        K_CLR_CARRY: s_nxt.cf = 1'b0;
                        K_CLR_DIR:   s_nxt.df = 1'b0;
                        K_INV_CARRY: s_nxt.cf = ~s_r.cf;
                        K_CLR_INTEN: begin
                            if (protMode && !privOk) begin
                                s_nxt.fault = 1'b1;
                            end else begin
                                s_nxt.ief = 1'b0;
                            end
                        end
                        K_CLR_TS: begin
                            if (protMode && !privOk) begin
                                s_nxt.fault = 1'b1;
                            end else begin
                                s_nxt.ts = 1'b0;
                            end
                        end
                        K_CMP: begin
                            {s_nxt.of, s_nxt.sf, s_nxt.zf,
                             s_nxt.af, s_nxt.pf, s_nxt.cf} = cmpRes;
                        end
                        K_CMOV: begin
                            // memory source may fault in protected mode
                            if (protMode && memOp && !privOk) begin
                                s_nxt.fault = 1'b1;
                            end else if (condMet(s_r.opc[3:0], s_r.of,
                                                 s_r.sf, s_r.zf, s_r.pf,
                                                 s_r.cf)) begin
                                s_nxt.wbV = 1'b1;
                                s_nxt.wbR = s_r.reg3;
                                s_nxt.wbD = rmValue;
                            end
                        end
                        default: s_nxt.bad = 1'b1;
                    endcase
                end
            end
            default: s_nxt.state = ST_IDLE;
        endcase
        // a task switch in the clearing cycle wins over the clear
        if (taskSwitchSet) begin
            s_nxt.ts = 1'b1;
        end
        s_nxt.rdy = (s_nxt.state != ST_EXEC);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r     <= '0;
            s_r.ief <= INTEN_RST;
            s_r.ts  <= TS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign byteReady     = s_r.rdy;
    assign modrmMod      = s_r.mod;
    assign modrmReg      = s_r.reg3;
    assign modrmRm       = s_r.rm;
    assign rmIsReg       = (s_r.mod == MOD_REGISTER);
    assign instrDone     = s_r.done;
    assign badOpcode     = s_r.bad;
    assign modeFault     = s_r.fault;
    assign wbValid       = s_r.wbV;
    assign wbReg         = s_r.wbR;
    assign wbData        = s_r.wbD;
    assign carryFlag     = s_r.cf;
    assign directionFlag = s_r.df;
    assign intEnableFlag = s_r.ief;
    assign overflowFlag  = s_r.of;
    assign signFlag      = s_r.sf;
    assign zeroFlag      = s_r.zf;
    assign auxCarryFlag  = s_r.af;
    assign parityFlag    = s_r.pf;
    assign taskSwitched  = s_r.ts;

endmodule

// ---- src/iod_pkg.sv ----
// Purpose: shared constants and types of the integer opcode decode slice
// Assumes: one instruction byte offered per cycle by the fetch stage
// Notes:   clock counts are core clocks with register or cache-hit operands

package iod_pkg;

    // ------------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_SEXT_BW   = 8'h98;
    localparam logic [7:0] OP_SEXT_DQ   = 8'h99;
    localparam logic [7:0] OP_CLR_CARRY = 8'hF8;
    localparam logic [7:0] OP_CLR_DIR   = 8'hFC;
    localparam logic [7:0] OP_CLR_INTEN = 8'hFA;
    localparam logic [7:0] OP_INV_CARRY = 8'hF5;
    localparam logic [7:0] OP_ESCAPE    = 8'h0F;
    localparam logic [7:0] OP2_CLR_TS   = 8'h06;
    // upper opcode bits of the compare and conditional move families
    localparam logic [5:0] CMP_MODRM_HI = 6'h0E;
    localparam logic [6:0] CMP_ACC_HI   = 7'h1E;
    localparam logic [5:0] CMP_GRP_HI   = 6'h20;
    localparam logic [3:0] CMOV_HI      = 4'h4;
    // opcode bit positions
    localparam int         BIT_W        = 0;
    localparam int         BIT_DS       = 1;

    // ------------------------------------------------------------------
    // modrm and condition codes
    // ------------------------------------------------------------------
    localparam logic [1:0] MOD_REGISTER = 2'h3;
    localparam logic [2:0] GRP_REG_CMP  = 3'h7;
    localparam logic [2:0] CC_OVF       = 3'h0;
    localparam logic [2:0] CC_CARRY     = 3'h1;
    localparam logic [2:0] CC_ZERO      = 3'h2;
    localparam logic [2:0] CC_BELOW_EQ  = 3'h3;
    localparam logic [2:0] CC_SIGN      = 3'h4;
    localparam logic [2:0] CC_PARITY    = 3'h5;
    localparam logic [2:0] CC_LESS      = 3'h6;
    localparam logic [2:0] CC_LESS_EQ   = 3'h7;

    // ------------------------------------------------------------------
    // register indices, immediate lengths, clock counts, reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_ACC      = 3'h0;
    localparam logic [2:0] REG_DATA     = 3'h2;
    localparam logic [1:0] IMM_LAST_B   = 2'h0;
    localparam logic [1:0] IMM_LAST_D   = 2'h3;
    localparam logic [3:0] CYC_SEXT_BW  = 4'h3;
    localparam logic [3:0] CYC_SEXT_DQ  = 4'h2;
    localparam logic [3:0] CYC_CLR_CY   = 4'h1;
    localparam logic [3:0] CYC_CLR_DIR  = 4'h7;
    localparam logic [3:0] CYC_CLR_IE   = 4'h7;
    localparam logic [3:0] CYC_CLR_TS   = 4'hA;
    localparam logic [3:0] CYC_INV_CY   = 4'h2;
    localparam logic [3:0] CYC_CMP      = 4'h1;
    localparam logic [3:0] CYC_CMOV     = 4'h1;
    localparam logic [3:0] CNT_LAST     = 4'h1;
    localparam logic       INTEN_RST    = 1'b0;
    localparam logic       TS_RST       = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ESC   = 3'b001,
        ST_MODRM = 3'b010,
        ST_IMM   = 3'b011,
        ST_EXEC  = 3'b100
    } iod_state_t;

    typedef enum logic [3:0] {
        K_NONE      = 4'b0000,
        K_SEXT_BW   = 4'b0001,
        K_SEXT_DQ   = 4'b0010,
        K_CLR_CARRY = 4'b0011,
        K_CLR_DIR   = 4'b0100,
        K_CLR_INTEN = 4'b0101,
        K_CLR_TS    = 4'b0110,
        K_INV_CARRY = 4'b0111,
        K_CMP       = 4'b1000,
        K_CMOV      = 4'b1001
    } iod_kind_t;

endpackage

// ---- verif/iod_decode_assertions.sv ----
// Purpose: port timing and flag checks of the decode slice
// Assumes: taskSwitchSet stays low while a task clear runs
// Notes:   a helper flop marks where the next opcode starts
`timescale 1ns/1ps
module iod_decode_assertions
    import iod_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // byte stream
    input wire logic       byteValid,
    input wire logic [7:0] byteData,
    input wire logic       byteReady,
    // retirement
    input wire logic       instrDone,
    input wire logic       badOpcode,
    input wire logic       modeFault,
    input wire logic       wbValid,
    input wire logic [2:0] wbReg,
    // flags
    input wire logic       carryFlag,
    input wire logic       directionFlag,
    input wire logic       intEnableFlag,
    input wire logic       taskSwitched
);
    logic take, opStart, opTake, atStart_r;
    assign take    = byteValid && byteReady;
    assign opStart = atStart_r || instrDone || badOpcode;
    assign opTake  = opStart && take;
    // operand bytes equal to an opcode must not trigger the checks
    always_ff @(posedge clk) begin
        atStart_r <= !rst_n || (opStart && !take);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sext_bw_a: assert property (opTake && byteData == OP_SEXT_BW
        |-> ##4 instrDone && wbValid && wbReg == REG_ACC) else $error("widen");
    sext_dq_a: assert property (opTake && byteData == OP_SEXT_DQ
        |-> ##3 instrDone && wbValid && wbReg == REG_DATA) else $error("fill");
    clr_carry_a: assert property (
        opTake && byteData == OP_CLR_CARRY
        |-> ##2 instrDone && !carryFlag) else $error("carry clear");
    clr_dir_a: assert property (opTake && byteData == OP_CLR_DIR
        |-> ##8 instrDone && !directionFlag) else $error("dir clear");
    clr_inten_a: assert property (
        opTake && byteData == OP_CLR_INTEN
        |-> ##8 instrDone && (modeFault || !intEnableFlag)) else $error("ie");
    inv_carry_a: assert property (
        opTake && byteData == OP_INV_CARRY
        |-> ##3 instrDone && carryFlag != $past(carryFlag, 3))
        else $error("inv");
    ready_busy_a: assert property (
        opTake && byteData == OP_SEXT_BW
        |=> !byteReady [*3] ##1 byteReady) else $error("ready");
    clr_ts_a: assert property (
        opTake && byteData == OP_ESCAPE ##1
        take && byteData == OP2_CLR_TS |-> ##11 instrDone
        && (modeFault || !taskSwitched)) else $error("task clear");
    cmp_acc_a: assert property (opTake && byteData == 8'h3C
        ##1 take |-> ##2 instrDone) else $error("compare time");
    cmov_time_a: assert property (
        opTake && byteData == OP_ESCAPE
        ##1 take && byteData[7:4] == CMOV_HI ##1 take |-> ##2 instrDone)
        else $error("move time");
    fault_done_a: assert property (modeFault
        |-> instrDone && !wbValid) else $error("fault");
endmodule
bind iod_decode_core iod_decode_assertions chk (.clk(clk), .rst_n(rst_n),
    .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady),
    .instrDone(instrDone), .badOpcode(badOpcode), .modeFault(modeFault),
    .wbValid(wbValid), .wbReg(wbReg), .carryFlag(carryFlag),
    .directionFlag(directionFlag), .intEnableFlag(intEnableFlag),
    .taskSwitched(taskSwitched));

// ---- verif/tb_iod_decode_core.sv ----
// Purpose: directed bench for the integer opcode decode slice
// Assumes: operands always hit; bench plays fetch and registers
// Notes:   cycles run from the edge taking the last byte
`timescale 1ns/1ps
module tb_iod_decode_core;
    import iod_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, byteValid = 1'b0;
    logic        protMode = 1'b0, privOk = 1'b1, taskSwitchSet = 1'b0;
    logic [7:0]  byteData = 8'h00;
    logic [31:0] accValue = 32'h0, regValue = 32'h0, rmValue = 32'h0;
    logic [31:0] wbData;
    logic [1:0]  modrmMod;
    logic [2:0]  modrmReg, modrmRm, wbReg;
    logic        byteReady, rmIsReg, instrDone, badOpcode, modeFault;
    logic        wbValid, carryFlag, directionFlag, intEnableFlag;
    logic        overflowFlag, signFlag, zeroFlag, auxCarryFlag;
    logic        parityFlag, taskSwitched, gotWb, gotFault, gotBad;
    logic [5:0]  flags;
    int          nErrors = 0, numChecks = 0, cyc;
    assign flags = {overflowFlag, signFlag, zeroFlag, auxCarryFlag,
                    parityFlag, carryFlag};
    iod_decode_core dut (.*);
    always #50 clk = ~clk;
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [34:0] seen, exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic sendB(input logic [7:0] b);
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (byteReady === 1'b1) break;
            byteValid = 1'b0;
        end
        if (i == 40) begin
            nErrors++;
            tally_and_finish();
        end
        byteValid = 1'b1;
        byteData = b;
        @(posedge clk);
    endtask
    // sends whole instruction, waits for retire or refusal
    task automatic run(input logic [7:0] q[$]);
        int i;
        foreach (q[k]) sendB(q[k]);
        for (i = 1; i <= 40; i++) begin
            @(negedge clk);
            byteValid = 1'b0;
            if (instrDone === 1'b1 || badOpcode === 1'b1) break;
        end
        if (i > 40) begin
            nErrors++;
            tally_and_finish();
        end
        cyc = i;
        gotWb = wbValid;
        gotFault = modeFault;
        gotBad = badOpcode;
    endtask
    // {carry, zero, sign, overflow} of an 8-bit subtract
    function automatic logic [3:0] czso(input logic [7:0] a, b);
        logic [7:0] d;
        d = a - b;
        return {a < b, a == b, d[7], (a[7] != b[7]) && (d[7] != a[7])};
    endfunction
    function automatic logic taken(input logic [7:0] op, logic [3:0] f);
        case (op)
            8'h47: return !f[3] && !f[2];
            8'h46: return f[3] || f[2];
            8'h43: return !f[3];
            8'h42: return f[3];
            8'h44: return f[2];
            8'h45: return !f[2];
            8'h4F: return !f[2] && f[1] == f[0];
            8'h4E: return f[2] || f[1] != f[0];
            default: return f[1] != f[0];
        endcase
    endfunction
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic cmpCase(input logic [7:0] q[$], input logic [31:0] a,
                           input logic [31:0] r, m, input logic [5:0] f);
        accValue = a;
        regValue = r;
        rmValue = m;
        run(q);
        check("cmp cycles", cyc, 2);
        check("cmp flags", flags, f);
    endtask
    task automatic t_cmp();
        cmpCase('{8'h3C, 8'h05}, 32'h3, 32'h0, 32'h0, 6'h15);
        cmpCase('{8'h39, 8'hC1}, 32'h0, 32'h55, 32'h55, 6'h0A);
        cmpCase('{8'h83, 8'hF8, 8'h05}, 32'h0, 32'h0, 32'h3, 6'h15);
        cmpCase('{8'h3D, 8'h05, 8'h00, 8'h00, 8'h80}, 32'h8000_0005,
                32'h0, 32'h0, 6'h0A);
        check("grp reg", {modrmReg, rmIsReg}, 4'hF);
        cmpCase('{8'h3B, 8'h41}, 32'h0, 32'h5, 32'h3, 6'h00);
        check("mem form", {modrmMod, rmIsReg}, 3'h2);
        check("rm field", modrmRm, 3'h1);
        run('{8'h80, 8'hC0});
        check("grp refuse", gotBad, 1'b1);
    endtask
    task automatic t_sext();
        accValue = 32'h1234_0080;
        run('{OP_SEXT_BW});
        check("cbw cycles", cyc, 4);
        check("cbw data", {gotWb, wbData}, 33'h1_1234_FF80);
        check("cbw flags", flags, 6'h00);
        accValue = 32'h8000_0000;
        run('{OP_SEXT_DQ});
        check("cdq cycles", cyc, 3);
        check("cdq data", {wbReg, wbData}, 35'h2_FFFF_FFFF);
        check("cdq flags", flags, 6'h00);
    endtask
    task automatic t_flags();
        cmpCase('{8'h3C, 8'h05}, 32'h3, 32'h0, 32'h0, 6'h15);
        run('{OP_INV_CARRY});
        check("cmc", {cyc[3:0], flags}, 10'h0D4);
        run('{OP_INV_CARRY});
        check("cmc back", flags, 6'h15);
        run('{OP_CLR_CARRY});
        check("clc", {cyc[3:0], flags}, 10'h094);
        run('{OP_CLR_DIR});
        check("cld", {cyc[3:0], directionFlag}, 5'h10);
        taskSwitchSet = 1'b1;
        @(negedge clk);
        taskSwitchSet = 1'b0;
        run('{OP_ESCAPE, OP2_CLR_TS});
        check("clear_task_switched_op", {cyc[3:0], taskSwitched}, 5'h16);
        protMode = 1'b1;
        privOk = 1'b0;
        taskSwitchSet = 1'b1;
        @(negedge clk);
        taskSwitchSet = 1'b0;
        run('{OP_ESCAPE, OP2_CLR_TS});
        check("clear_task_switched_op fault", {gotFault, taskSwitched}, 2'h3);
        run('{OP_CLR_INTEN});
        check("cli fault", {cyc[3:0], gotFault}, 5'h11);
        privOk = 1'b1;
        run('{OP_CLR_INTEN});
        check("cli", {gotFault, intEnableFlag}, 2'h0);
    endtask
    task automatic t_cmov();
        logic [7:0] ops[9] = '{8'h47, 8'h46, 8'h43, 8'h42, 8'h44, 8'h45,
                               8'h4F, 8'h4E, 8'h4C};
        logic [7:0] av[4] = '{8'h03, 8'h05, 8'h05, 8'h80};
        logic [7:0] iv[4] = '{8'h05, 8'h05, 8'h03, 8'h01};
        logic [3:0] f;
        logic       e;
        for (int j = 0; j < 4; j++) begin
            accValue = {24'h0, av[j]};
            run('{8'h3C, iv[j]});
            f = czso(av[j], iv[j]);
            for (int k = 0; k < 9; k++) begin
                e = taken(ops[k], f);
                rmValue = {24'hA5C3E1, ops[k]};
                run('{OP_ESCAPE, ops[k], 8'hC8});
                check("cmov time", cyc, 2);
                check("cmov move", gotWb, e);
                if (e) check("cmov data", {wbReg, wbData},
                             {3'h1, rmValue});
                check("cmov flags", {carryFlag, zeroFlag, signFlag,
                      overflowFlag}, f);
            end
        end
        privOk = 1'b0;
        run('{OP_ESCAPE, 8'h43, 8'h48});
        check("cmov fault", {gotFault, gotWb}, 2'h2);
        protMode = 1'b0;
        privOk = 1'b1;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_cmp();
        t_sext();
        t_flags();
        t_cmov();
        tally_and_finish();
    end
endmodule
